// ---- common/ccg_params.svh ----
`ifndef CCG_PARAMS_SVH
`define CCG_PARAMS_SVH

// ***********************************************************
// Synchronised pin vector layout
// ***********************************************************
`define CCG_PIN_W 11
`define CCG_PIN_XTAL 0
`define CCG_PIN_EFI 1
`define CCG_PIN_SRC_SEL 2
`define CCG_PIN_ALIGN 3
`define CCG_PIN_RSEL 4
`define CCG_PIN_RSEL_DRV 5
`define CCG_PIN_RDY_A 6
`define CCG_PIN_RDY_B 7
`define CCG_PIN_AEN_A 8
`define CCG_PIN_AEN_B 9
`define CCG_PIN_POR 10

// ***********************************************************
// Divider phase codes (one-hot)
// ***********************************************************
`define CCG_PH_HOLD_CODE 4'h1
`define CCG_PH_HIGH_CODE 4'h2
`define CCG_PH_LOW1_CODE 4'h4
`define CCG_PH_LOW2_CODE 4'h8

// ***********************************************************
// Reset values and counts
// ***********************************************************
`define CCG_PIN_RST 11'h000
`define CCG_BIT_LOW 1'h0
`define CCG_BIT_HIGH 1'h1
`define CCG_EDGE_CNT_RST 2'h0
`define CCG_EDGE_CNT_ONE 2'h1
`define CCG_EDGES_BETWEEN_RISES 2'h2
`define CCG_PULLUP_LEVEL 1'h1

`endif

// ---- common/ccg_pkg.sv ----
package ccg_pkg;
  `include "ccg_params.svh"

  typedef enum logic [3:0] {
    CCG_PH_HOLD = `CCG_PH_HOLD_CODE,
    CCG_PH_HIGH = `CCG_PH_HIGH_CODE,
    CCG_PH_LOW1 = `CCG_PH_LOW1_CODE,
    CCG_PH_LOW2 = `CCG_PH_LOW2_CODE
  } ccg_phase_t;

  typedef struct packed {
    logic [`CCG_PIN_W-1:0] pin_meta;
    logic [`CCG_PIN_W-1:0] pin_sync;
    logic src_prev;
    ccg_phase_t phase;
    logic clk_cpu;
    logic pclk;
    logic cpu_reset;
    logic osc;
    logic xtal_b;
    logic [1:0] chk_edges;
    logic chk_run;
  } ccg_top_state_t;

  typedef struct packed {
    logic first_stage;
    logic second_stage;
  } ccg_rsync_state_t;
endpackage

// ---- common/ccg_rsync_if.sv ----
`timescale 1ns/1ps
interface ccg_rsync_if;
  logic cpu_rise;
  logic cpu_fall;
  logic ready_in;
  logic single_mode;
  logic ready_out;
  logic first_stage;

  modport ctl (
    output cpu_rise,
    output cpu_fall,
    output ready_in,
    output single_mode,
    input ready_out,
    input first_stage
  );

  modport sync (
    input cpu_rise,
    input cpu_fall,
    input ready_in,
    input single_mode,
    output ready_out,
    output first_stage
  );
endinterface

// ---- src/ccg_ready_sync.sv ----
`timescale 1ns/1ps
`include "ccg_params.svh"
module ccg_ready_sync (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Ready path
  ccg_rsync_if.sync rs
);
  import ccg_pkg::*;

  ccg_rsync_state_t st;
  ccg_rsync_state_t next_st;

  always_comb begin
    next_st = st;
    if (rs.cpu_rise) begin
      next_st.first_stage = rs.ready_in;
    end
    if (rs.cpu_fall) begin
      if (rs.single_mode) begin
        next_st.second_stage = rs.ready_in;
      end else if (rs.ready_in) begin
        next_st.second_stage = st.first_stage;
      end else begin
        next_st.second_stage = `CCG_BIT_LOW;
      end
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      st <= '{first_stage: `CCG_BIT_LOW, second_stage: `CCG_BIT_LOW};
    end else begin
      st <= next_st;
    end
  end

  assign rs.ready_out = st.second_stage;
  assign rs.first_stage = st.first_stage;
endmodule

// ---- src/ccg_top.sv ----
`timescale 1ns/1ps
`include "ccg_params.svh"
// Notes on behaviour
// - Select low: ready passes two synchronising stages.
// - Select high: ready passes one synchronising stage.
// - Undriven select reads high through the internal pull-up, single stage.
// - CPU clock is the selected source divided by three.
// - Peripheral clock runs at half the CPU clock.
// - Source select high picks external input, low picks crystal.
// - Oscillator output always shows the raw crystal signal.
// - Two-stage high: first stage on CPU rise, output on next fall.
// - Two-stage low: output stage falls directly on CPU fall.
// - Single stage: output stage samples both levels on CPU fall.
// - Divider state after power-up is not meaningful; alignment fixes it.
// - Align high holds divider and drives both clocks high.
// - After align falls, clock restarts at next source rise.
// - CPU clock is one third high, two thirds low.
// - Peripheral clock has equal high and low times.
// - Each ready input counts only while its enable is low.
// - CPU reset output is inverted reset input, CPU-clock synchronised.
module ccg_top (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Clock sources
  input wire logic crystal_pin_a_i,
  output logic crystal_pin_b_o,
  input wire logic external_freq_input_i,
  input wire logic source_select_i,
  // Divider alignment
  input wire logic divider_align_in_i,
  // Bus ready
  input wire logic bus_ready_a_i,
  input wire logic bus_ready_b_i,
  input wire logic ready_a_enable_n_i,
  input wire logic ready_b_enable_n_i,
  input wire logic ready_sync_select_n_i,
  input wire logic ready_sync_select_drv_i,
  output logic ready_o,
  // CPU reset
  input wire logic power_on_clear_in_n_i,
  output logic cpu_reset_o,
  // Clock outputs
  output logic clk_cpu_o,
  output logic pclk_o,
  output logic oscillator_out_o
);
  import ccg_pkg::*;

  // ***********************************************************
  // State and synchronised pins
  // ***********************************************************
  ccg_top_state_t st;
  ccg_top_state_t next_st;
  ccg_rsync_if rs ();

  logic [`CCG_PIN_W-1:0] pins;
  logic [`CCG_PIN_W-1:0] ps;
  logic src;
  logic src_rise;
  logic align;
  logic single_mode;
  logic ready_in;
  logic cpu_rise;
  logic cpu_fall;

  always_comb begin
    pins = `CCG_PIN_RST;
    pins[`CCG_PIN_XTAL] = crystal_pin_a_i;
    pins[`CCG_PIN_EFI] = external_freq_input_i;
    pins[`CCG_PIN_SRC_SEL] = source_select_i;
    pins[`CCG_PIN_ALIGN] = divider_align_in_i;
    pins[`CCG_PIN_RSEL] = ready_sync_select_n_i;
    pins[`CCG_PIN_RSEL_DRV] = ready_sync_select_drv_i;
    pins[`CCG_PIN_RDY_A] = bus_ready_a_i;
    pins[`CCG_PIN_RDY_B] = bus_ready_b_i;
    pins[`CCG_PIN_AEN_A] = ready_a_enable_n_i;
    pins[`CCG_PIN_AEN_B] = ready_b_enable_n_i;
    pins[`CCG_PIN_POR] = power_on_clear_in_n_i;
  end

  assign ps = st.pin_sync;
  assign src = ps[`CCG_PIN_SRC_SEL] ? ps[`CCG_PIN_EFI] : ps[`CCG_PIN_XTAL];
  assign src_rise = src & ~st.src_prev;
  assign align = ps[`CCG_PIN_ALIGN];
  assign single_mode = ps[`CCG_PIN_RSEL_DRV] ? ps[`CCG_PIN_RSEL] : `CCG_PULLUP_LEVEL;
  assign ready_in = (ps[`CCG_PIN_RDY_A] & ~ps[`CCG_PIN_AEN_A]) |
                    (ps[`CCG_PIN_RDY_B] & ~ps[`CCG_PIN_AEN_B]);
  assign cpu_rise = ~align & src_rise & (st.phase == CCG_PH_LOW2);
  assign cpu_fall = ~align & src_rise & (st.phase == CCG_PH_HIGH);

  // ***********************************************************
  // Next state
  // ***********************************************************
  always_comb begin
    next_st = st;
    next_st.pin_meta = pins;
    next_st.pin_sync = st.pin_meta;
    next_st.src_prev = src;
    next_st.osc = ps[`CCG_PIN_XTAL];
    next_st.xtal_b = ~ps[`CCG_PIN_XTAL];
    if (align) begin
      next_st.phase = CCG_PH_HOLD;
      next_st.clk_cpu = `CCG_BIT_HIGH;
      next_st.pclk = `CCG_BIT_HIGH;
    end else if (src_rise) begin
      case (st.phase)
        CCG_PH_HOLD: begin
          next_st.phase = CCG_PH_HIGH;
          next_st.clk_cpu = `CCG_BIT_HIGH;
        end
        CCG_PH_HIGH: begin
          next_st.phase = CCG_PH_LOW1;
          next_st.clk_cpu = `CCG_BIT_LOW;
        end
        CCG_PH_LOW1: begin
          next_st.phase = CCG_PH_LOW2;
          next_st.clk_cpu = `CCG_BIT_LOW;
        end
        CCG_PH_LOW2: begin
          next_st.phase = CCG_PH_HIGH;
          next_st.clk_cpu = `CCG_BIT_HIGH;
          next_st.pclk = ~st.pclk;
        end
        default: begin
          next_st.phase = CCG_PH_HOLD;
          next_st.clk_cpu = `CCG_BIT_HIGH;
        end
      endcase
    end
    if (cpu_fall) begin
      next_st.cpu_reset = ~ps[`CCG_PIN_POR];
    end
    // Observation counter of source edges between CPU rises
    if (align) begin
      next_st.chk_run = `CCG_BIT_LOW;
      next_st.chk_edges = `CCG_EDGE_CNT_RST;
    end else if (cpu_rise) begin
      next_st.chk_run = `CCG_BIT_HIGH;
      next_st.chk_edges = `CCG_EDGE_CNT_RST;
    end else if (src_rise) begin
      next_st.chk_edges = st.chk_edges + `CCG_EDGE_CNT_ONE;
    end
  end

  // ***********************************************************
  // Registers
  // ***********************************************************
  // arbitrary but defined start
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      st.pin_meta <= `CCG_PIN_RST;
      st.pin_sync <= `CCG_PIN_RST;
      st.src_prev <= `CCG_BIT_LOW;
      st.phase <= CCG_PH_HOLD;
      st.clk_cpu <= `CCG_BIT_HIGH;
      st.pclk <= `CCG_BIT_HIGH;
      st.cpu_reset <= `CCG_BIT_HIGH;
      st.osc <= `CCG_BIT_LOW;
      st.xtal_b <= `CCG_BIT_HIGH;
      st.chk_edges <= `CCG_EDGE_CNT_RST;
      st.chk_run <= `CCG_BIT_LOW;
    end else begin
      st <= next_st;
    end
  end

  // ***********************************************************
  // Ready synchroniser
  // ***********************************************************
  assign rs.cpu_rise = cpu_rise;
  assign rs.cpu_fall = cpu_fall;
  assign rs.ready_in = ready_in;
  assign rs.single_mode = single_mode;

  ccg_ready_sync u_ready (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .rs(rs.sync)
  );

  assign ready_o = rs.ready_out;
  assign cpu_reset_o = st.cpu_reset;
  assign clk_cpu_o = st.clk_cpu;
  assign pclk_o = st.pclk;
  assign oscillator_out_o = st.osc;
  assign crystal_pin_b_o = st.xtal_b;

  // ***********************************************************
  // Assertions
  // ***********************************************************
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);

  sequence fall_two_stage_s;
    cpu_fall && !single_mode;
  endsequence

  sequence hold_release_s;
    st.phase == CCG_PH_HOLD && !align && src_rise;
  endsequence

  sequence low_phase_s;
    !clk_cpu_o && (st.phase == CCG_PH_LOW1 || st.phase == CCG_PH_LOW2);
  endsequence

  property two_stage_high_p;
    fall_two_stage_s and ready_in |=> ready_o == $past(rs.first_stage);
  endproperty

  property two_stage_low_p;
    fall_two_stage_s and !ready_in |=> !ready_o;
  endproperty

  property rise_needs_first_p;
    $rose(ready_o) && !$past(single_mode) |-> $past(rs.first_stage);
  endproperty

  // Two stage high path
  two_stage_high_a: assert property (two_stage_high_p)
    else $error("two-stage ready did not follow first stage");

  // Low bypass
  ready_low_bypass_a: assert property (two_stage_low_p)
    else $error("two-stage ready did not fall on CPU fall");

  // Rise only after first stage
  ready_rise_first_a: assert property (rise_needs_first_p)
    else $error("ready rose without first stage high");

  // Single stage path
  single_stage_a: assert property (
    cpu_fall && single_mode |=> ready_o == $past(ready_in))
    else $error("single-stage ready did not sample input");

  // Ready moves only on CPU fall
  ready_stable_a: assert property (
    !cpu_fall |=> $stable(ready_o))
    else $error("ready changed away from CPU fall");

  // Pull-up default
  select_pullup_a: assert property (
    !ps[`CCG_PIN_RSEL_DRV] |-> single_mode)
    else $error("undriven select not single stage");

  // Divider period
  divide_three_a: assert property (
    cpu_rise && st.chk_run |-> st.chk_edges == `CCG_EDGES_BETWEEN_RISES)
    else $error("CPU clock period not three source edges");

  // Peripheral toggle
  pclk_toggle_a: assert property (
    cpu_rise |=> pclk_o != $past(pclk_o))
    else $error("peripheral clock missed a toggle");

  // Peripheral stable between rises
  pclk_stable_a: assert property (
    !cpu_rise && !align |=> $stable(pclk_o))
    else $error("peripheral clock changed off a CPU rise");

  // Oscillator passthrough
  osc_pass_a: assert property (
    !$past(rst_i, 3) |-> oscillator_out_o == $past(crystal_pin_a_i, 3))
    else $error("oscillator output not raw crystal");

  // Source selection
  source_pick_a: assert property (
    !$past(rst_i, 2) |-> src == (ps[`CCG_PIN_SRC_SEL] ? $past(external_freq_input_i, 2)
                                 : $past(crystal_pin_a_i, 2)))
    else $error("wrong clock source used");

  // Align hold
  align_hold_a: assert property (
    align |=> clk_cpu_o && pclk_o && st.phase == CCG_PH_HOLD)
    else $error("align did not hold clocks high");

  // Restart after align
  align_restart_a: assert property (
    hold_release_s |=> st.phase == CCG_PH_HIGH && clk_cpu_o)
    else $error("clock did not restart on source rise");

  // CPU clock low in a low phase after fall
  duty_third_a: assert property (
    cpu_fall |=> low_phase_s)
    else $error("CPU clock not low after fall");

  // Reset output level
  reset_follow_a: assert property (
    cpu_fall |=> cpu_reset_o == !$past(ps[`CCG_PIN_POR]))
    else $error("CPU reset not inverse of input");

  // Reset output timing
  reset_on_fall_a: assert property (
    !cpu_fall |=> $stable(cpu_reset_o))
    else $error("CPU reset changed off CPU fall");

  // Enable gating
  ready_gate_a: assert property (
    ps[`CCG_PIN_AEN_A] && ps[`CCG_PIN_AEN_B] |-> !ready_in)
    else $error("disabled ready input was used");
endmodule

// ---- tb/ccg_src_model.sv ----
`timescale 1ns/1ps
// ****
// Source clocks and align retiming
// ****
module ccg_src_model #(
  parameter int XH = 3,
  parameter int EH = 4
) (
  input wire logic mclk_i,
  input wire logic source_select_i,
  input wire logic align_req_i,
  output logic crystal_o,
  output logic efi_o,
  output logic align_o
);
  int xc = 0;
  int ec = 0;
  logic xr;
  logic er;
  initial crystal_o = 0;
  initial efi_o = 0;
  initial align_o = 0;
  always @(posedge mclk_i) begin
    #1;
    xc = (xc == XH - 1) ? 0 : xc + 1;
    ec = (ec == EH - 1) ? 0 : ec + 1;
    xr = (xc == 0) && !crystal_o;
    er = (ec == 0) && !efi_o;
    if (xc == 0) begin
      crystal_o <= ~crystal_o;
    end
    if (ec == 0) begin
      efi_o <= ~efi_o;
    end
    if (source_select_i ? er : xr) begin
      align_o <= align_req_i;
    end
  end
endmodule

// ---- tb/cpu_clock_ready_reset_gen_tb.sv ----
`timescale 1ns/1ps
module cpu_clock_ready_reset_gen_tb;
  logic mclk_i = 0;
  logic rst_i = 1;
  logic src_sel = 0;
  logic align_req = 0;
  logic rdy_a = 0, rdy_b = 0, aen_a = 1, aen_b = 1;
  logic sel_n = 1, sel_drv = 0, por_n = 1;
  logic xtal, external_freq_input, align, rdy, cpu_rst, clk_cpu, pclk, osc, xb;
  logic [3:0] hist = 4'h0;
  int errors = 0;
  int check_count = 0;
  int hi, lo, m2, m3;
  logic [31:0] ck_rows [2][3] = '{'{0, 6, 12}, '{1, 8, 16}};
  logic [7:0] rd_rows [6] = '{8'hCB, 8'h89, 8'hFC, 8'hE7, 8'h0B, 8'h84};

  always #5 mclk_i = ~mclk_i;

  ccg_src_model src (.mclk_i(mclk_i), .source_select_i(src_sel), .align_req_i(align_req),
    .crystal_o(xtal), .efi_o(external_freq_input), .align_o(align));

  ccg_top uut (.mclk_i(mclk_i), .rst_i(rst_i), .crystal_pin_a_i(xtal),
    .crystal_pin_b_o(xb), .external_freq_input_i(external_freq_input), .source_select_i(src_sel),
    .divider_align_in_i(align), .bus_ready_a_i(rdy_a), .bus_ready_b_i(rdy_b),
    .ready_a_enable_n_i(aen_a), .ready_b_enable_n_i(aen_b),
    .ready_sync_select_n_i(sel_n), .ready_sync_select_drv_i(sel_drv), .ready_o(rdy),
    .power_on_clear_in_n_i(por_n), .cpu_reset_o(cpu_rst), .clk_cpu_o(clk_cpu),
    .pclk_o(pclk), .oscillator_out_o(osc));

  // ****
  // Helpers
  // ****
  task step();
    @(posedge mclk_i);
    #1;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask

  task report_and_stop();
    $display("Checks %0d, mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  function logic pick(int w);
    return (w == 0) ? clk_cpu : pclk;
  endfunction

  // Waits for a new transition of the chosen clock into lvl
  task edge_wait(input logic lvl, input int w);
    logic prev;
    int n;
    prev = pick(w);
    n = 0;
    step();
    while (!(pick(w) === lvl && prev !== lvl)) begin
      prev = pick(w);
      step();
      n++;
      if (n > 300) begin
        errors++;
        $display("CHECK FAILED at %0t: edge timeout", $time);
        report_and_stop();
      end
    end
  endtask

  task hold_len(input int w, input logic lvl, output int n);
    n = 0;
    while (pick(w) === lvl && n < 400) begin
      n++;
      step();
    end
    if (n >= 400) begin
      errors++;
      $display("CHECK FAILED at %0t: level timeout", $time);
      report_and_stop();
    end
  endtask

  initial begin
    repeat (4) step();
    chk(cpu_rst, 1, "reset out in reset");
    chk(rdy, 0, "ready in reset");
    rst_i = 0;
    $display("Test reset done");
    // ****
    // Clock rows
    // ****
    foreach (ck_rows[i]) begin
      src_sel = ck_rows[i][0];
      repeat (60) step();
      edge_wait(1, 0);
      hold_len(0, 1, hi);
      hold_len(0, 0, lo);
      chk(hi, ck_rows[i][1], "cpu clock high time");
      chk(lo, ck_rows[i][2], "cpu clock low time");
      edge_wait(1, 1);
      hold_len(1, 1, hi);
      hold_len(1, 0, lo);
      chk(hi, ck_rows[i][1] + ck_rows[i][2], "pclk high time");
      chk(lo, ck_rows[i][1] + ck_rows[i][2], "pclk low time");
      m2 = 0;
      m3 = 0;
      hi = 0;
      repeat (28) begin
        step();
        hist = {hist[2:0], xtal};
        m2 += (osc !== hist[2]);
        m3 += (osc !== hist[3]);
        hi += (xb !== ~osc);
      end
      chk((m2 <= 4) || (m3 <= 4), 1, "oscillator output");
      chk(hi, 0, "second crystal pin not inverse");
      $display("Test clock row %0d done", i);
    end
    src_sel = 0;
    // ****
    // Ready rows: mode, select, enables
    // ****
    foreach (rd_rows[i]) begin
      {sel_drv, sel_n, rdy_a, aen_a, rdy_b, aen_b} = {rd_rows[i][7:6], 1'b0, rd_rows[i][4], 1'b0, rd_rows[i][2]};
      edge_wait(0, 0);
      edge_wait(1, 0);
      rdy_a = rd_rows[i][5];
      rdy_b = rd_rows[i][3];
      edge_wait(0, 0);
      chk(rdy, rd_rows[i][1], "ready after one fall");
      edge_wait(1, 0);
      edge_wait(0, 0);
      chk(rdy, rd_rows[i][0], "ready after two falls");
      $display("Test ready row %0d done", i);
    end
    // ****
    // Two-stage low bypass
    // ****
    {sel_drv, sel_n, rdy_a, aen_a} = 4'hA;
    edge_wait(0, 0);
    edge_wait(1, 0);
    edge_wait(0, 0);
    chk(rdy, 1, "two-stage ready high");
    edge_wait(1, 0);
    rdy_a = 0;
    edge_wait(0, 0);
    chk(rdy, 0, "two-stage ready low");
    $display("Test ready bypass done");
    // ****
    // CPU reset output
    // ****
    edge_wait(1, 0);
    por_n = 0;
    repeat (3) step();
    chk(cpu_rst, 0, "reset out before fall");
    edge_wait(0, 0);
    chk(cpu_rst, 1, "reset out set");
    edge_wait(1, 0);
    por_n = 1;
    edge_wait(0, 0);
    chk(cpu_rst, 0, "reset out cleared");
    $display("Test cpu reset done");
    // ****
    // Divider alignment
    // ****
    align_req = 1;
    repeat (30) step();
    m2 = 0;
    repeat (20) begin
      step();
      m2 += (clk_cpu !== 1) || (pclk !== 1);
    end
    chk(m2, 0, "clocks held high");
    align_req = 0;
    edge_wait(0, 0);
    hold_len(0, 0, lo);
    hold_len(0, 1, hi);
    chk(lo, 12, "low time after align");
    chk(hi, 6, "high time after align");
    $display("Test align done");
    report_and_stop();
  end
endmodule
